// >>> src/io_function_assignment.sv
// top of the i/o function assignment block: registers, pin mapping and consistency checks
`timescale 1ns/10ps
module io_function_assignment
  import io_assign_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic [NUM_IN-1:0] in_pin_raw,
  input wire logic [NOUT_FN-1:0] out_func_src,
  output logic [NUM_OUT-1:0] out_pin,
  output logic [NFUNC-1:0] drive_func,
  output logic [NS_W-1:0] net_status,
  output logic [PROT_W-1:0] prot_code,
  output logic prot_active
);
  io_map_if m ();

  // software-visible configuration
  logic [SEL_W-1:0] in_sel_reg [NUM_IN];    // input selection per pin
  logic [SEL_W-1:0] out_sel_reg [NUM_OUT];  // output selection per pin
  logic [5:0] ctrl_reg;                     // mode, homing trigger, inhibit config
  logic load_reg;                           // run the checks next cycle
  logic [PROT_W-1:0] prot_reg;              // held protection codes
  logic [DATA_W-1:0] rd_data_reg;           // read answer
  logic [NUM_OUT-1:0] out_pin_reg;
  logic [NFUNC-1:0] drive_func_reg;
  logic [NS_W-1:0] net_status_reg;
  logic prot_active_reg;                    // summary of the held codes, kept in a flop

  // control fields
  mode_t mode;
  home_trig_t home_sel;
  logic [1:0] ot_cfg;
  logic [1:0] mode_idx;          // byte lane of the running mode
  logic home_on;                 // a homing trigger is selected
  logic [FI_W-1:0] home_fi;      // its function slot
  int home_pin;                  // its allowed pin
  assign mode = mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign home_sel = home_trig_t'(ctrl_reg[CTRL_HOME_LSB +: 2]);
  assign ot_cfg = ctrl_reg[CTRL_OT_LSB +: 2];
  assign mode_idx = (mode == MODE_POS) ? 2'd0 : ((mode == MODE_VEL) ? 2'd1 : 2'd2);
  assign home_on = (home_sel != HT_NONE);
  assign home_fi = (home_sel == HT_POT) ? FI_POT : ((home_sel == HT_NOT) ? FI_NOT : FI_HOME);
  assign home_pin = (home_sel == HT_POT) ? PIN_SIX : ((home_sel == HT_NOT) ? PIN_SEVEN : PIN_FIVE);

  // register decode
  logic sel_in_hit;
  logic sel_out_hit;
  logic [2:0] in_ix;
  logic [1:0] out_ix;
  assign sel_in_hit = (addr < (REG_IN_SEL0 + ADDR_W'(NUM_IN)));
  assign sel_out_hit = (addr >= REG_OUT_SEL0) && (addr < (REG_OUT_SEL0 + ADDR_W'(NUM_OUT)));
  assign in_ix = 3'(addr - REG_IN_SEL0);
  assign out_ix = 2'(addr - REG_OUT_SEL0);

  // read mux; unmapped words read zero
  logic [DATA_W-1:0] rd_mux;
  assign rd_mux = sel_in_hit ? DATA_W'(in_sel_reg[in_ix]) :
                  sel_out_hit ? DATA_W'(out_sel_reg[out_ix]) :
                  (addr == REG_CTRL) ? DATA_W'(ctrl_reg) :
                  (addr == REG_PROT) ? DATA_W'(prot_reg) :
                  (addr == REG_STATUS) ? DATA_W'(net_status_reg) : '0;

  // selection registers; upper byte is outside the range and never stored
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < NUM_IN; p++) begin
        in_sel_reg[p] <= (p == NUM_IN - 1) ? IN8_SEL_RST : IN_SEL_RST;
      end
      out_sel_reg[0] <= OUT1_SEL_RST;
      out_sel_reg[1] <= OUT2_SEL_RST;
      out_sel_reg[2] <= OUT3_SEL_RST;
    end else if (wr_en && sel_in_hit) begin
      in_sel_reg[in_ix] <= wr_data[SEL_W-1:0] & SEL_MASK;
    end else if (wr_en && sel_out_hit) begin
      out_sel_reg[out_ix] <= wr_data[SEL_W-1:0] & SEL_MASK;
    end
  end

  // control register and load pulse; a check also runs right after reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RST;
      load_reg <= 1'b1;
    end else begin
      if (wr_en && (addr == REG_CTRL)) begin
        ctrl_reg <= wr_data[5:0];
      end
      load_reg <= wr_en && (addr == REG_LOAD) && wr_data[0];
    end
  end

  // read data stand for the one cycle after the strobe only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_en ? rd_mux : '0;
    end
  end

  // consistency checks across all pins and modes
  logic [NUM_IN-1:0] fmask [NUM_MODES][NFUNC];   // pins carrying each function
  logic fpol [NUM_MODES][NFUNC];                 // polarity seen per function
  logic [NUM_IN-1:0] latch_role;                 // pin acts as latch pin in some mode
  logic [PROT_W-1:0] err;
  always_comb begin
    fn_dec_t d;
    d = fn_decode(FC_NONE);
    err = '0;
    latch_role = '0;
    for (int k = 0; k < NUM_MODES; k++) begin
      for (int f = 0; f < NFUNC; f++) begin
        fmask[k][f] = '0;
        fpol[k][f] = 1'b0;
      end
    end
    for (int k = 0; k < NUM_MODES; k++) begin
      for (int p = 0; p < NUM_IN; p++) begin
        d = fn_decode(in_sel_reg[p][k*FN_W +: FN_W]);
        if (d.ok) begin
          fmask[k][d.idx][p] = 1'b1;
          fpol[k][d.idx] = fpol[k][d.idx] | d.bpol;
          // latch triggers and the homing trigger make a latch pin
          if ((d.idx == FI_LT1) || (d.idx == FI_LT2) || (d.idx == FI_LT3) || (home_on && (d.idx == home_fi))) begin
            latch_role[p] = 1'b1;
          end
        end else if (in_sel_reg[p][k*FN_W +: FN_W] != FC_NONE) begin
          // unlisted code, including a b-contact latch trigger
          err[PB_33_3] = 1'b1;
        end
      end
    end
    for (int k = 0; k < NUM_MODES; k++) begin
      for (int f = 0; f < NFUNC; f++) begin
        // one function on two pins in one mode
        if ((fmask[k][f] & (fmask[k][f] - 1'b1)) != '0) begin
          err[PB_33_0] = 1'b1;
        end
        for (int j = 0; j < NUM_MODES; j++) begin
          if ((fmask[k][f] != '0) && (fmask[j][f] != '0)) begin
            if (fmask[k][f] != fmask[j][f]) begin
              err[PB_33_1] = 1'b1;
            end
            if (fpol[k][f] != fpol[j][f]) begin
              err[PB_33_2] = 1'b1;
            end
          end
        end
      end
      // monitor inputs share status bits with their partners
      for (int q = 0; q < 5; q++) begin
        if ((fmask[k][FI_MON1 + FI_W'(q)] != '0) &&
            (fmask[k][(q == 0) ? FI_LT1 : (q == 1) ? FI_LT2 : (q == 2) ? FI_LT3 : (q == 3) ? FI_SON : FI_ESTOP] != '0)) begin
          err[PB_33_0] = 1'b1;
        end
      end
      // latch triggers only on their own pin
      if ((fmask[k][FI_LT1] & ~(NUM_IN'(1) << PIN_FIVE)) != '0) begin
        err[PB_33_8] = 1'b1;
      end
      if ((fmask[k][FI_LT2] & ~(NUM_IN'(1) << PIN_SIX)) != '0) begin
        err[PB_33_8] = 1'b1;
      end
      if ((fmask[k][FI_LT3] & ~(NUM_IN'(1) << PIN_SEVEN)) != '0) begin
        err[PB_33_8] = 1'b1;
      end
      // homing trigger only on its own pin
      if (home_on && ((fmask[k][home_fi] & ~(NUM_IN'(1) << home_pin)) != '0)) begin
        err[PB_33_8] = 1'b1;
      end
    end
    // a latch pin must be set in every mode and only with a-contact codes
    for (int p = 0; p < NUM_IN; p++) begin
      if (latch_role[p]) begin
        for (int k = 0; k < NUM_MODES; k++) begin
          if (in_sel_reg[p][k*FN_W +: FN_W] == FC_NONE) begin
            err[PB_33_8] = 1'b1;
          end
          if (in_sel_reg[p][k*FN_W + BPOL_BIT]) begin
            err[PB_33_8] = 1'b1;
          end
        end
      end
    end
    // overtravel homing needs the inhibit disabled
    if (((home_sel == HT_POT) || (home_sel == HT_NOT)) && (ot_cfg != OT_CFG_DISABLE)) begin
      err[PB_38_2] = 1'b1;
    end
  end

  // protection codes gather on each load and stay until reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prot_reg <= '0;
      prot_active_reg <= 1'b0;
    end else if (load_reg) begin
      prot_reg <= prot_reg | err;
      // summary follows the same update so it never lags the codes
      prot_active_reg <= |(prot_reg | err);
    end
  end

  // running-mode codes and raw pins to the slices
  always_comb begin
    for (int p = 0; p < NUM_IN; p++) begin
      m.in_code[p] = in_sel_reg[p][{mode_idx, 3'b000} +: FN_W];
    end
    for (int o = 0; o < NUM_OUT; o++) begin
      m.out_code[o] = out_sel_reg[o][{mode_idx, 3'b000} +: FN_W];
    end
  end
  assign m.in_raw = in_pin_raw;
  assign m.latch_pin = latch_role;
  assign m.out_src = out_func_src;

  // one slice per input pin and per output pin
  for (genvar g = 0; g < NUM_IN; g++) begin : g_in
    input_decode #(.IDX(g)) u_in (.m(m.in_slice));
  end
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    output_select #(.IDX(g)) u_out (.m(m.out_slice));
  end

  // gather active functions; a pin set to 00h contributes nothing
  logic [NFUNC-1:0] func_or;
  logic [NUM_OUT-1:0] out_lvl_vec;
  always_comb begin
    func_or = '0;
    for (int p = 0; p < NUM_IN; p++) begin
      func_or = func_or | m.in_act[p];
    end
    for (int o = 0; o < NUM_OUT; o++) begin
      out_lvl_vec[o] = m.out_lvl[o];
    end
  end

  // status word; each monitor shares a bit with its partner
  logic [NS_W-1:0] ns_next;
  assign ns_next[NS_POT] = func_or[FI_POT];
  assign ns_next[NS_NOT] = func_or[FI_NOT];
  assign ns_next[NS_HOME] = func_or[FI_HOME];
  assign ns_next[NS_LT1] = func_or[FI_LT1] | func_or[FI_MON1];
  assign ns_next[NS_LT2] = func_or[FI_LT2] | func_or[FI_MON2];
  assign ns_next[NS_LT3] = func_or[FI_LT3] | func_or[FI_MON3];
  assign ns_next[NS_SON] = func_or[FI_SON] | func_or[FI_MON4];
  assign ns_next[NS_ESTOP] = func_or[FI_ESTOP] | func_or[FI_MON5];

  // registered pin and status outputs; one cycle of delay keeps outputs glitch free
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drive_func_reg <= '0;
      net_status_reg <= '0;
      out_pin_reg <= '0;
    end else begin
      drive_func_reg <= func_or;
      net_status_reg <= ns_next;
      out_pin_reg <= out_lvl_vec;
    end
  end

  assign rd_data = rd_data_reg;
  assign out_pin = out_pin_reg;
  assign drive_func = drive_func_reg;
  assign net_status = net_status_reg;
  assign prot_code = prot_reg;
  assign prot_active = prot_active_reg;
endmodule

// >>> src/io_assign_pkg.sv
// constants, codes, register map and decode function for the i/o function assignment block
package io_assign_pkg;
  localparam int NUM_IN = 8;           // general input pins
  localparam int NUM_OUT = 3;          // general output pins
  localparam int NUM_MODES = 3;        // position/full-closed, velocity, torque
  localparam int FN_W = 8;             // one function byte per mode
  localparam int SEL_W = 24;           // selection parameter width
  localparam int NFUNC = 13;           // input function slots
  localparam int FI_W = 4;
  localparam int NOUT_FN = 18;         // output functions 00h..11h
  localparam int OUT_IDX_W = 5;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int PROT_W = 6;
  localparam int NS_W = 8;
  localparam int BPOL_BIT = 7;         // b-contact marker inside the code
  localparam logic [SEL_W-1:0] SEL_MASK = 24'hFFFFFF;
  localparam logic [FN_W-1:0] FC_NONE = 8'h00;
  localparam logic [FN_W-1:0] FC_POT_A = 8'h01;
  localparam logic [FN_W-1:0] FC_POT_B = 8'h81;
  localparam logic [FN_W-1:0] FC_NOT_A = 8'h02;
  localparam logic [FN_W-1:0] FC_NOT_B = 8'h82;
  localparam logic [FN_W-1:0] FC_SON_A = 8'h03;
  localparam logic [FN_W-1:0] FC_SON_B = 8'h83;
  localparam logic [FN_W-1:0] FC_ESTOP_A = 8'h14;
  localparam logic [FN_W-1:0] FC_ESTOP_B = 8'h94;
  localparam logic [FN_W-1:0] FC_LT1_A = 8'h20;
  localparam logic [FN_W-1:0] FC_LT2_A = 8'h21;
  localparam logic [FN_W-1:0] FC_HOME_A = 8'h22;
  localparam logic [FN_W-1:0] FC_HOME_B = 8'hA2;
  localparam logic [FN_W-1:0] FC_LT3_A = 8'h2B;
  localparam logic [FN_W-1:0] FC_MON1_A = 8'h2E;
  localparam logic [FN_W-1:0] FC_MON2_A = 8'h2F;
  localparam logic [FN_W-1:0] FC_MON3_A = 8'h30;
  localparam logic [FN_W-1:0] FC_MON4_A = 8'h31;
  localparam logic [FN_W-1:0] FC_MON5_A = 8'h32;
  localparam logic [FN_W-1:0] FC_MON1_B = 8'hAE;
  localparam logic [FN_W-1:0] FC_MON2_B = 8'hAF;
  localparam logic [FN_W-1:0] FC_MON3_B = 8'hB0;
  localparam logic [FN_W-1:0] FC_MON4_B = 8'hB1;
  localparam logic [FN_W-1:0] FC_MON5_B = 8'hB2;
  // function slot indices
  localparam logic [FI_W-1:0] FI_POT = 4'h0;
  localparam logic [FI_W-1:0] FI_NOT = 4'h1;
  localparam logic [FI_W-1:0] FI_SON = 4'h2;
  localparam logic [FI_W-1:0] FI_ESTOP = 4'h3;
  localparam logic [FI_W-1:0] FI_LT1 = 4'h4;
  localparam logic [FI_W-1:0] FI_LT2 = 4'h5;
  localparam logic [FI_W-1:0] FI_HOME = 4'h6;
  localparam logic [FI_W-1:0] FI_LT3 = 4'h7;
  localparam logic [FI_W-1:0] FI_MON1 = 4'h8;
  localparam logic [FI_W-1:0] FI_MON2 = 4'h9;
  localparam logic [FI_W-1:0] FI_MON3 = 4'hA;
  localparam logic [FI_W-1:0] FI_MON4 = 4'hB;
  localparam logic [FI_W-1:0] FI_MON5 = 4'hC;
  // zero-based pin numbers of the latch correction pins
  localparam int PIN_FIVE = 4;
  localparam int PIN_SIX = 5;
  localparam int PIN_SEVEN = 6;
  // register word addresses
  localparam logic [ADDR_W-1:0] REG_IN_SEL0 = 5'h00;
  localparam logic [ADDR_W-1:0] REG_OUT_SEL0 = 5'h08;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_LOAD = 5'h0D;
  localparam logic [ADDR_W-1:0] REG_PROT = 5'h0E;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h0F;
  // reset values
  localparam logic [SEL_W-1:0] IN_SEL_RST = 24'h000000;
  localparam logic [SEL_W-1:0] IN8_SEL_RST = 24'h313131;
  localparam logic [SEL_W-1:0] OUT1_SEL_RST = 24'h030303;
  localparam logic [SEL_W-1:0] OUT2_SEL_RST = 24'h101010;
  localparam logic [SEL_W-1:0] OUT3_SEL_RST = 24'h010101;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HOME_LSB = 2;
  localparam int CTRL_OT_LSB = 4;
  localparam logic [1:0] OT_CFG_DISABLE = 2'h1;
  // protection code bits
  localparam int PB_33_0 = 0;
  localparam int PB_33_1 = 1;
  localparam int PB_33_2 = 2;
  localparam int PB_33_3 = 3;
  localparam int PB_33_8 = 4;
  localparam int PB_38_2 = 5;
  // network status bits, shared pairs on one bit
  localparam int NS_POT = 0;
  localparam int NS_NOT = 1;
  localparam int NS_HOME = 2;
  localparam int NS_LT1 = 3;
  localparam int NS_LT2 = 4;
  localparam int NS_LT3 = 5;
  localparam int NS_SON = 6;
  localparam int NS_ESTOP = 7;

  typedef enum logic [1:0] {MODE_POS = 2'b00, MODE_VEL = 2'b01, MODE_TRQ = 2'b11} mode_t;
  typedef enum logic [1:0] {HT_NONE = 2'b00, HT_HOME = 2'b01, HT_POT = 2'b11, HT_NOT = 2'b10} home_trig_t;
  typedef struct packed {
    logic ok;
    logic bpol;
    logic [FI_W-1:0] idx;
  } fn_dec_t;

  // map a function byte to its slot; unlisted codes are not ok
  function automatic fn_dec_t fn_decode(input logic [FN_W-1:0] code);
    fn_dec_t d;
    d.ok = 1'b1;
    d.bpol = code[BPOL_BIT];
    d.idx = FI_POT;
    case (code)
      FC_POT_A, FC_POT_B: d.idx = FI_POT;
      FC_NOT_A, FC_NOT_B: d.idx = FI_NOT;
      FC_SON_A, FC_SON_B: d.idx = FI_SON;
      FC_ESTOP_A, FC_ESTOP_B: d.idx = FI_ESTOP;
      FC_LT1_A: d.idx = FI_LT1;
      FC_LT2_A: d.idx = FI_LT2;
      FC_HOME_A, FC_HOME_B: d.idx = FI_HOME;
      FC_LT3_A: d.idx = FI_LT3;
      FC_MON1_A, FC_MON1_B: d.idx = FI_MON1;
      FC_MON2_A, FC_MON2_B: d.idx = FI_MON2;
      FC_MON3_A, FC_MON3_B: d.idx = FI_MON3;
      FC_MON4_A, FC_MON4_B: d.idx = FI_MON4;
      FC_MON5_A, FC_MON5_B: d.idx = FI_MON5;
      default: d.ok = 1'b0;
    endcase
    return d;
  endfunction
endpackage

// >>> src/io_map_if.sv
// interface carrying per-pin codes and levels between the core and its pin slices
`timescale 1ns/10ps
interface io_map_if;
  import io_assign_pkg::*;
  logic [FN_W-1:0] in_code [NUM_IN];      // active-mode code per input pin
  logic [NUM_IN-1:0] in_raw;              // optocoupler conducting per pin
  logic [NUM_IN-1:0] latch_pin;           // pin serves as latch correction pin
  logic [NFUNC-1:0] in_act [NUM_IN];      // one-hot active function per pin
  logic [FN_W-1:0] out_code [NUM_OUT];    // active-mode code per output pin
  logic [NOUT_FN-1:0] out_src;            // output function levels
  logic out_lvl [NUM_OUT];                // selected level per output pin
  modport core (output in_code, in_raw, latch_pin, out_code, out_src, input in_act, out_lvl);
  modport in_slice (input in_code, in_raw, latch_pin, output in_act);
  modport out_slice (input out_code, out_src, output out_lvl);
endinterface

// >>> src/input_decode.sv
// one input pin slice: code decode and contact polarity
`timescale 1ns/10ps
module input_decode
  import io_assign_pkg::*;
#(
  parameter int IDX = 0
) (
  io_map_if.in_slice m
);
  fn_dec_t dec;        // decoded function byte
  logic accept;        // code usable on this pin
  logic logical_on;    // function activated
  assign dec = fn_decode(m.in_code[IDX]);
  // 00h and unlisted codes never reach the drive
  assign accept = dec.ok && !(m.latch_pin[IDX] && dec.bpol);
  // a-contact on when conducting, b-contact on when dark
  assign logical_on = m.in_raw[IDX] ^ dec.bpol;
  assign m.in_act[IDX] = (accept && logical_on) ? (NFUNC'(1) << dec.idx) : '0;
endmodule

// >>> src/output_select.sv
// one output pin slice: picks the level of its assigned output function
`timescale 1ns/10ps
module output_select
  import io_assign_pkg::*;
#(
  parameter int IDX = 0
) (
  io_map_if.out_slice m
);
  logic in_range;    // code names a known output function
  assign in_range = (m.out_code[IDX] != FC_NONE) && (m.out_code[IDX] < FN_W'(NOUT_FN));
  // any function may go to any pin; unknown or 00h keeps the transistor off
  assign m.out_lvl[IDX] = in_range ? m.out_src[m.out_code[IDX][OUT_IDX_W-1:0]] : 1'b0;
endmodule

// >>> sim/io_assign_checker.sv
// assertion checker on the top ports of the i/o function assignment block
`timescale 1ns/10ps
module io_assign_checker
  import io_assign_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [NUM_IN-1:0] in_pin_raw,
  input wire logic [NOUT_FN-1:0] out_func_src,
  input wire logic [NUM_OUT-1:0] out_pin,
  input wire logic [NFUNC-1:0] drive_func,
  input wire logic [NS_W-1:0] net_status,
  input wire logic [PROT_W-1:0] prot_code,
  input wire logic prot_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // bus decodes as seen at the ports; unmapped holes are 0x0B and the upper half
  wire load_req = wr_en && addr == REG_LOAD && wr_data[0];
  wire rd_prot = rd_en && addr == REG_PROT;
  wire rd_stat = rd_en && addr == REG_STATUS;
  wire rd_unm = rd_en && (addr == 5'h0B || addr[4]);
  // read data is zero outside its one-cycle slot
  property p_rd_idle; !$past(rd_en) |-> rd_data == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_unm; $past(rd_unm) |-> rd_data == '0; endproperty
  a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
  property p_rd_prot; $past(rd_prot) |-> rd_data == {26'h0, $past(prot_code)}; endproperty
  a_rd_prot: assert property (p_rd_prot) else $error("protection read differs from held code");
  property p_rd_stat; $past(rd_stat) |-> rd_data == {24'h0, $past(net_status)}; endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status read differs from status port");
  // held codes never drop without a reset, and only move two cycles after a load
  property p_prot_hold; (prot_code & $past(prot_code)) == $past(prot_code); endproperty
  a_prot_hold: assert property (p_prot_hold) else $error("protection bit dropped");
  property p_prot_cause; $changed(prot_code) |-> $past(load_req, 2); endproperty
  a_prot_cause: assert property (p_prot_cause) else $error("protection moved without load");
  property p_prot_or; prot_active == (|prot_code); endproperty
  a_prot_or: assert property (p_prot_or) else $error("active flag not or of codes");
  // the LT1 and SON shared status bits carry either member of their pair
  property p_ns_pair;
    net_status[NS_LT1] == (drive_func[FI_LT1] | drive_func[FI_MON1]) &&
    net_status[NS_SON] == (drive_func[FI_SON] | drive_func[FI_MON4]);
  endproperty
  a_ns_pair: assert property (p_ns_pair) else $error("shared status bit wrong");
  c_load: cover property (load_req ##2 prot_active);
  c_read: cover property (rd_prot ##1 rd_data != '0);
  c_out: cover property ($rose(out_pin[2]));
endmodule
bind io_function_assignment io_assign_checker u_chk (.core_clk(core_clk), .rstn(rstn), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .in_pin_raw(in_pin_raw),
  .out_func_src(out_func_src), .out_pin(out_pin), .drive_func(drive_func), .net_status(net_status),
  .prot_code(prot_code), .prot_active(prot_active));

// >>> sim/io_far_side.sv
// external switches and relay loads hanging on the pins
`timescale 1ns/10ps
module io_far_side
  import io_assign_pkg::*;
(
  input wire logic core_clk,
  input wire logic [NUM_IN-1:0] sw_closed,
  input wire logic [NUM_OUT-1:0] out_pin,
  output logic [NUM_IN-1:0] in_pin_raw,
  output logic [NUM_OUT-1:0] load_on
);
  // open switches at power-up, so no optocoupler conducts
  initial in_pin_raw = '0;
  // a closed switch conducts one edge later, like a debounced contact
  always @(posedge core_clk) begin
    in_pin_raw <= sw_closed;
  end
  // relay loads follow the transistors
  assign load_on = out_pin;
endmodule

// >>> sim/io_function_assignment_tb.sv
// self-checking bench for the i/o function assignment block
`timescale 1ns/10ps
module io_function_assignment_tb
  import io_assign_pkg::*;
;
  localparam logic [31:0] pin8_dflt = 32'h00313131; // pin eight reset selection
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [NUM_IN-1:0] sw_closed = '0;
  logic [NOUT_FN-1:0] out_func_src = '0;
  logic [DATA_W-1:0] rd_data;
  logic [NUM_IN-1:0] in_pin_raw;
  logic [NUM_OUT-1:0] out_pin;
  logic [NUM_OUT-1:0] load_on;
  logic [NFUNC-1:0] drive_func;
  logic [NS_W-1:0] net_status;
  logic [PROT_W-1:0] prot_code;
  logic prot_active;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #20 core_clk = ~core_clk;
  io_function_assignment dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .in_pin_raw(in_pin_raw), .out_func_src(out_func_src),
    .out_pin(out_pin), .drive_func(drive_func), .net_status(net_status), .prot_code(prot_code),
    .prot_active(prot_active));
  io_far_side far (.core_clk(core_clk), .sw_closed(sw_closed), .out_pin(out_pin), .in_pin_raw(in_pin_raw),
    .load_on(load_on));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe; the release edge keeps back-to-back writes apart
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  // read data only stands in the cycle after the strobe, so take it mid-cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    d = rd_data;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
  endtask
  // reset values, dropped top byte, read-only and unmapped places
  task automatic t_regs();
    rc(5'h08, 32'h00030303, "out1 sel");
    rc(5'h09, 32'h00101010, "out2 sel");
    rc(5'h0A, 32'h00010101, "out3 sel");
    rc(5'h07, pin8_dflt, "in8 sel");
    rc(5'h0B, 32'h0, "unmapped");
    wr(5'h0A, 32'hFFFFFFFF);
    wr(REG_PROT, 32'h0000003F);
    rc(5'h0A, 32'h00FFFFFF, "out3 wide");
    rc(REG_PROT, 32'h0, "prot ro");
    $display("register test done");
  endtask
  // every listed code on a legal pin, both contact senses, switch open and closed
  task automatic t_inputs();
    logic [7:0] code [13] = '{8'h01, 8'h02, 8'h03, 8'h14, 8'h22, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32,
                              8'h20, 8'h21, 8'h2B};
    int slot [13] = '{0, 1, 2, 3, 6, 8, 9, 10, 11, 12, 4, 5, 7};
    int nsb [13] = '{0, 1, 6, 7, 2, 3, 4, 5, 6, 7, 3, 4, 5}; // status bit of each code
    int k;
    int pin;
    logic [7:0] c;
    do_reset();
    wr(5'h07, 32'h0);
    for (int i = 0; i < 23; i++) begin
      k = i % 13;
      pin = (k < 10) ? 0 : k - 6;
      c = code[k] | ((i >= 13) ? 8'h80 : 8'h00);
      wr(ADDR_W'(pin), {8'h00, c, c, c});
      for (int r = 0; r < 2; r++) begin
        @(posedge core_clk);
        sw_closed <= (r == 1) ? (8'h01 << pin) : 8'h00;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("drive_func", (r ^ (i >= 13)) ? (13'h1 << slot[k]) : 13'h0, drive_func);
        chk("net_status", (r ^ (i >= 13)) ? (32'h1 << nsb[k]) : 32'h0, net_status);
      end
      wr(ADDR_W'(pin), 32'h0);
    end
    // every pin now at 00h: closed contacts must do nothing
    @(posedge core_clk);
    sw_closed <= 8'hFF;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("idle funcs", 32'h0, {drive_func, net_status});
    sw_closed <= 8'h00;
    $display("input test done");
  endtask
  // fresh reset, two selections, control, load, then the held code
  task automatic pc(input logic [4:0] a1, input logic [31:0] v1, input logic [4:0] a2, input logic [31:0] v2,
                    input logic [5:0] ctl, input logic [5:0] exp);
    logic [31:0] d;
    do_reset();
    wr(a1, v1);
    wr(a2, v2);
    wr(REG_CTRL, {26'h0, ctl});
    wr(REG_LOAD, 32'h00000001);
    rd(REG_PROT, d);
    chk("prot bits", {26'h0, exp}, d & {26'h0, (exp == 6'h00) ? 6'h3F : exp});
    chk("prot_active", {31'h0, exp != 6'h00}, {31'h0, prot_active});
  endtask
  task automatic t_prot();
    pc(5'h00, 32'h00010101, 5'h01, 32'h00010101, 6'h00, 6'h01);
    wr(5'h01, 32'h0);
    wr(REG_LOAD, 32'h00000001);
    rc(REG_PROT, 32'h00000001, "prot held");
    pc(5'h00, 32'h00000001, 5'h01, 32'h00000100, 6'h00, 6'h02);
    pc(5'h00, 32'h00018101, 5'h07, pin8_dflt, 6'h00, 6'h04);
    pc(5'h04, 32'h00A0A0A0, 5'h07, pin8_dflt, 6'h00, 6'h08);
    pc(5'h00, 32'h00202020, 5'h07, pin8_dflt, 6'h00, 6'h10);
    pc(5'h04, 32'h00000020, 5'h07, pin8_dflt, 6'h00, 6'h10);
    pc(5'h04, 32'h00A2A2A2, 5'h07, pin8_dflt, 6'h04, 6'h10);
    pc(5'h05, 32'h00222222, 5'h07, pin8_dflt, 6'h04, 6'h10);
    pc(5'h05, 32'h00010101, 5'h07, pin8_dflt, 6'h0C, 6'h20);
    pc(5'h05, 32'h00010101, 5'h07, pin8_dflt, 6'h1C, 6'h00);
    pc(5'h00, 32'h002E2E2E, 5'h04, 32'h00202020, 6'h00, 6'h01);
    pc(5'h04, 32'h00202020, 5'h05, 32'h00212121, 6'h00, 6'h00);
    pc(5'h06, 32'h002B2B2B, 5'h07, pin8_dflt, 6'h00, 6'h00);
    $display("protection test done");
  endtask
  // a different function per mode byte on pin three, defaults on pins one and two
  task automatic t_out();
    int fn;
    do_reset();
    wr(5'h0A, 32'h00110502);
    for (int m = 0; m < 3; m++) begin
      fn = (m == 0) ? 2 : ((m == 1) ? 5 : 17);
      wr(REG_CTRL, (m == 0) ? 32'h0 : ((m == 1) ? 32'h1 : 32'h3));
      for (int v = 0; v < 2; v++) begin
        @(posedge core_clk);
        out_func_src <= (v == 1) ? (18'h1 << fn) : ~(18'h1 << fn);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("loads", {29'h0, v[0], !v[0], !v[0]}, {29'h0, load_on});
      end
    end
    $display("output test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard well above the several hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_inputs();
    t_prot();
    t_out();
    final_report();
  end
endmodule
